// *** pkg/e3rx_cfg.svh ***
// Offsets, field positions, reset values and timing constants of the E3 receive control block
`ifndef E3RX_CFG_SVH
`define E3RX_CFG_SVH
// Register indices; byte address is four times the index
`define E3RX_IDX_CTRL 8'h20
`define E3RX_IDX_LIVE_A 8'h24
`define E3RX_IDX_LIVE_B 8'h26
`define E3RX_IDX_LAT_A 8'h28
`define E3RX_IDX_LAT_B 8'h2A
`define E3RX_IDX_IE_A 8'h2C
`define E3RX_IDX_IE_B 8'h2E
`define E3RX_IDX_FEC_CNT 8'h34
// Control field positions
`define E3RX_C_LINK_SRC 13
`define E3RX_C_MAN_AIS 12
`define E3RX_C_AUTO_AIS_DIS 11
`define E3RX_C_ECC 10
`define E3RX_C_FEC_HI 9
`define E3RX_C_FEC_LO 8
`define E3RX_C_RAI_LOF_EN 7
`define E3RX_C_RAI_LOS_DIS 6
`define E3RX_C_RAI_OOF_DIS 5
`define E3RX_C_RAI_AIS_DIS 4
`define E3RX_C_OH_MARK_DIS 3
`define E3RX_C_LIP_HI 2
`define E3RX_C_LIP_LO 1
`define E3RX_C_RESYNC 0
// Status field positions, A and B groups
`define E3RX_S_UA1 8
`define E3RX_S_RAB 7
`define E3RX_S_RNB 6
`define E3RX_S_COFA 5
`define E3RX_S_LOF 4
`define E3RX_S_RDI 3
`define E3RX_S_AIS 2
`define E3RX_S_OOF 1
`define E3RX_S_LOS 0
`define E3RX_S_FE_EV 8
`define E3RX_S_NZ 0
// Reset values and writable masks
`define E3RX_CTRL_RST 16'h0000
`define E3RX_CTRL_MASK 16'h3FFF
`define E3RX_LAT_A_MASK 16'h01FF
`define E3RX_LAT_B_MASK 16'h0101
`define E3RX_ZERO16 16'h0000
// Framing error limits
`define E3RX_FAS_BIT_MAX 4'hA
// LOF integration periods in milliseconds
`define E3RX_LIP_3MS_N 2'h3
`define E3RX_LIP_2MS_N 2'h2
`define E3RX_LIP_1MS_N 2'h1
// Timing base
`define E3RX_CLK_PERIOD_NS 5
`define E3RX_MS_NS 1000000
`endif

// *** pkg/e3rx_pkg.sv ***
// Types shared by the E3 receive control block
package e3rx_pkg;
  // Framing event selection
  typedef enum logic [1:0] {
    E3RX_FEC_OOF,
    E3RX_FEC_BIT,
    E3RX_FEC_WORD,
    E3RX_FEC_RSVD
  } e3rx_fec_sel_t;
  // LOF integration period selection
  typedef enum logic [1:0] {
    E3RX_LIP_3MS,
    E3RX_LIP_2MS,
    E3RX_LIP_1MS,
    E3RX_LIP_NONE
  } e3rx_lip_t;
endpackage

// *** src/e3rx_ctrl_status.sv ***
// E3 receive framer control, live and latched status, framing error counter, APB slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "e3rx_cfg.svh"
// How it works
// - Link select picks N or A bit for FEAC
// - Manual bit forces downstream AIS
// - LOS, OOF, AIS insert AIS unless disabled
// - Gating bit lets counting go on during OOF or AIS
// - Field picks OOF, FAS bit or word counting
// - LOF drives RAI when enabled
// - LOS drives RAI unless disabled
// - OOF drives RAI unless disabled
// - AIS drives RAI unless disabled
// - Overhead positions marked unless marking disabled
// - LOF after OOF lasts 3, 2 or 1 ms
// - Period code 11 makes LOF follow OOF
// - Resync bit rising edge forces OOF once
// - Live unframed all-ones status bit
// - Live integrated A and N bits
// - Live LOF, AIS and OOF bits
// - Live remote alarm bit
// - Live LOS bit follows the pin
// - Any live A-group bit change sets its latch
// - Interrupt needs latch, enable and port enable
// - Nonzero bit shows counter not zero
// - Nonzero rising edge sets its latch
module e3rx_ctrl_status #(
  parameter int MS_CYCLES = `E3RX_MS_NS / `E3RX_CLK_PERIOD_NS,
  parameter int CNT_W = 16
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signal_loss_input_i,
  input wire logic oof_i,
  input wire logic ais_i,
  input wire logic rdi_i,
  input wire logic unframed_all_ones_i,
  input wire logic rx_alarm_service_bit_i,
  input wire logic rx_national_service_bit_i,
  input wire logic svc_strobe_i,
  input wire logic svc_a_raw_i,
  input wire logic svc_n_raw_i,
  input wire logic frame_strobe_i,
  input wire logic [3:0] fas_bit_errs_i,
  input wire logic fas_word_error_i,
  input wire logic cofa_i,
  input wire logic overhead_pos_i,
  input wire logic port_status_irq_enable_i,
  output logic feac_bit_o,
  output logic feac_bit_valid_o,
  output logic downstream_ais_o,
  output logic auto_rai_o,
  output logic rx_payload_marker_n_o,
  output logic force_resync_o,
  output logic lof_o,
  output logic irq_o
);
  logic [15:0] ctrl_q;
  logic [15:0] live_a_q;
  logic [15:0] live_b_q;
  logic [15:0] live_a_d;
  logic [15:0] live_b_d;
  logic [15:0] lat_a_q;
  logic [15:0] lat_b_q;
  logic [15:0] ie_a_q;
  logic [15:0] ie_b_q;
  logic [15:0] chg_a;
  logic [15:0] wmask;
  logic [15:0] rd_mux;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W:0] cnt_sum;
  logic [3:0] inc;
  logic los_sync;
  logic lof_w;
  logic oof_prev_q;
  logic resync_prev_q;
  logic nz_prev_q;
  logic gate_ok;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic cnt_clr;
  e3rx_pkg::e3rx_fec_sel_t fec_sel;
  e3rx_pkg::e3rx_lip_t lip_sel;

  // Word-aligned index match
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[9:2] == idx) && (addr[11:10] == 2'h0);
  endfunction

  // APB decode; zero wait states, so pready is constant high
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign mapped = hit(paddr_i, `E3RX_IDX_CTRL) || hit(paddr_i, `E3RX_IDX_LIVE_A)
    || hit(paddr_i, `E3RX_IDX_LIVE_B) || hit(paddr_i, `E3RX_IDX_LAT_A)
    || hit(paddr_i, `E3RX_IDX_LAT_B) || hit(paddr_i, `E3RX_IDX_IE_A)
    || hit(paddr_i, `E3RX_IDX_IE_B) || hit(paddr_i, `E3RX_IDX_FEC_CNT);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign cnt_clr = rd_setup && hit(paddr_i, `E3RX_IDX_FEC_CNT);

  assign fec_sel = e3rx_pkg::e3rx_fec_sel_t'(ctrl_q[`E3RX_C_FEC_HI:`E3RX_C_FEC_LO]);
  assign lip_sel = e3rx_pkg::e3rx_lip_t'(ctrl_q[`E3RX_C_LIP_HI:`E3RX_C_LIP_LO]);

  // Read mux; reserved bits read zero
  always_comb begin
    rd_mux = `E3RX_ZERO16;
    if (hit(paddr_i, `E3RX_IDX_CTRL)) begin
      rd_mux = ctrl_q;
    end else if (hit(paddr_i, `E3RX_IDX_LIVE_A)) begin
      rd_mux = live_a_q;
    end else if (hit(paddr_i, `E3RX_IDX_LIVE_B)) begin
      rd_mux = live_b_q;
    end else if (hit(paddr_i, `E3RX_IDX_LAT_A)) begin
      rd_mux = lat_a_q;
    end else if (hit(paddr_i, `E3RX_IDX_LAT_B)) begin
      rd_mux = lat_b_q;
    end else if (hit(paddr_i, `E3RX_IDX_IE_A)) begin
      rd_mux = ie_a_q;
    end else if (hit(paddr_i, `E3RX_IDX_IE_B)) begin
      rd_mux = ie_b_q;
    end else if (hit(paddr_i, `E3RX_IDX_FEC_CNT)) begin
      rd_mux = 16'(cnt_q);
    end
  end

  // Read data captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= {`E3RX_ZERO16, rd_mux};
    end
  end

  // Control register and interrupt enables
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_q <= `E3RX_CTRL_RST;
      ie_a_q <= `E3RX_ZERO16;
      ie_b_q <= `E3RX_ZERO16;
    end else if (wr_en) begin
      if (hit(paddr_i, `E3RX_IDX_CTRL)) begin
        ctrl_q <= (ctrl_q & ~wmask) | (pwdata_i[15:0] & wmask & `E3RX_CTRL_MASK);
      end
      if (hit(paddr_i, `E3RX_IDX_IE_A)) begin
        ie_a_q <= (ie_a_q & ~wmask) | (pwdata_i[15:0] & wmask & `E3RX_LAT_A_MASK);
      end
      if (hit(paddr_i, `E3RX_IDX_IE_B)) begin
        ie_b_q <= (ie_b_q & ~wmask) | (pwdata_i[15:0] & wmask & `E3RX_LAT_B_MASK);
      end
    end
  end

  // Loss-of-signal pin comes from outside the clock domain
  e3rx_pin_sync u_los_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .pin_i(signal_loss_input_i),
    .level_o(los_sync)
  );

  e3rx_lof_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_lof_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .oof_i(oof_i),
    .period_i(lip_sel),
    .lof_o(lof_w)
  );
  assign lof_o = lof_w;

  // Live status images; COFA is an event and only appears latched
  always_comb begin
    live_a_d = `E3RX_ZERO16;
    live_a_d[`E3RX_S_UA1] = unframed_all_ones_i;
    live_a_d[`E3RX_S_RAB] = rx_alarm_service_bit_i;
    live_a_d[`E3RX_S_RNB] = rx_national_service_bit_i;
    live_a_d[`E3RX_S_LOF] = lof_w;
    live_a_d[`E3RX_S_RDI] = rdi_i;
    live_a_d[`E3RX_S_AIS] = ais_i;
    live_a_d[`E3RX_S_OOF] = oof_i;
    live_a_d[`E3RX_S_LOS] = los_sync;
    live_b_d = `E3RX_ZERO16;
    live_b_d[`E3RX_S_NZ] = (cnt_q != '0);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      live_a_q <= `E3RX_ZERO16;
      live_b_q <= `E3RX_ZERO16;
    end else begin
      live_a_q <= live_a_d;
      live_b_q <= live_b_d;
    end
  end

  // Change detect on live bits plus the COFA event
  always_comb begin
    chg_a = live_a_d ^ live_a_q;
    chg_a[`E3RX_S_COFA] = cofa_i;
  end

  // Latched bits: write one to clear, a new set in the same cycle wins
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lat_a_q <= `E3RX_ZERO16;
      lat_b_q <= `E3RX_ZERO16;
    end else begin
      if (wr_en && hit(paddr_i, `E3RX_IDX_LAT_A)) begin
        lat_a_q <= ((lat_a_q & ~(pwdata_i[15:0] & wmask)) | chg_a) & `E3RX_LAT_A_MASK;
      end else begin
        lat_a_q <= (lat_a_q | chg_a) & `E3RX_LAT_A_MASK;
      end
      if (wr_en && hit(paddr_i, `E3RX_IDX_LAT_B)) begin
        lat_b_q <= lat_b_q & ~(pwdata_i[15:0] & wmask);
      end
      if (live_b_d[`E3RX_S_NZ] && !nz_prev_q) begin
        lat_b_q[`E3RX_S_NZ] <= 1'b1;
      end
      if (fas_word_error_i) begin
        lat_b_q[`E3RX_S_FE_EV] <= 1'b1;
      end
    end
  end

  // Interrupt request needs latch, bit enable and port enable together
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= port_status_irq_enable_i && (|((lat_a_q & ie_a_q) | (lat_b_q & ie_b_q)));
    end
  end

  // Edge history for OOF counting, resync trigger and nonzero latch
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      oof_prev_q <= 1'b0;
      resync_prev_q <= 1'b0;
      nz_prev_q <= 1'b0;
    end else begin
      oof_prev_q <= oof_i;
      resync_prev_q <= ctrl_q[`E3RX_C_RESYNC];
      nz_prev_q <= live_b_d[`E3RX_S_NZ];
    end
  end

  // Only a rising edge resyncs; holding the bit high does nothing more
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      force_resync_o <= 1'b0;
    end else begin
      force_resync_o <= ctrl_q[`E3RX_C_RESYNC] && !resync_prev_q;
    end
  end

  // Counting gate ignored in OOF mode, which counts alarms themselves
  assign gate_ok = ctrl_q[`E3RX_C_ECC] || !(oof_i || ais_i);

  always_comb begin
    inc = 4'h0;
    case (fec_sel)
      e3rx_pkg::E3RX_FEC_OOF: inc = {3'h0, oof_i && !oof_prev_q};
      e3rx_pkg::E3RX_FEC_BIT: begin
        if (frame_strobe_i && gate_ok) begin
          inc = (fas_bit_errs_i > `E3RX_FAS_BIT_MAX) ? `E3RX_FAS_BIT_MAX : fas_bit_errs_i;
        end
      end
      e3rx_pkg::E3RX_FEC_WORD: inc = {3'h0, fas_word_error_i && gate_ok};
      default: inc = 4'h0;
    endcase
  end

  // Saturating counter, cleared by the read that samples it, new events kept
  assign cnt_sum = {1'b0, cnt_q} + (CNT_W + 1)'(inc);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (cnt_clr) begin
      cnt_q <= CNT_W'(inc);
    end else if (cnt_sum[CNT_W]) begin
      cnt_q <= '1;
    end else begin
      cnt_q <= cnt_sum[CNT_W-1:0];
    end
  end

  // Downstream path controls, all registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      downstream_ais_o <= 1'b0;
      auto_rai_o <= 1'b0;
      rx_payload_marker_n_o <= 1'b1;
      feac_bit_o <= 1'b0;
      feac_bit_valid_o <= 1'b0;
    end else begin
      downstream_ais_o <= ctrl_q[`E3RX_C_MAN_AIS]
        || (!ctrl_q[`E3RX_C_AUTO_AIS_DIS] && (los_sync || oof_i || ais_i));
      auto_rai_o <= (ctrl_q[`E3RX_C_RAI_LOF_EN] && lof_w)
        || (!ctrl_q[`E3RX_C_RAI_LOS_DIS] && los_sync)
        || (!ctrl_q[`E3RX_C_RAI_OOF_DIS] && oof_i)
        || (!ctrl_q[`E3RX_C_RAI_AIS_DIS] && ais_i);
      // Active low: low marks data, high marks overhead
      rx_payload_marker_n_o <= overhead_pos_i && !ctrl_q[`E3RX_C_OH_MARK_DIS];
      feac_bit_valid_o <= svc_strobe_i;
      if (svc_strobe_i) begin
        feac_bit_o <= ctrl_q[`E3RX_C_LINK_SRC] ? svc_a_raw_i : svc_n_raw_i;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  feac_source_a: assert property (svc_strobe_i |=> feac_bit_o ==
    ($past(ctrl_q[`E3RX_C_LINK_SRC]) ? $past(svc_a_raw_i) : $past(svc_n_raw_i)))
    else $error("FEAC bit from wrong source");
  manual_ais_a: assert property (ctrl_q[`E3RX_C_MAN_AIS] |=> downstream_ais_o)
    else $error("Manual AIS not inserted");
  auto_ais_a: assert property (!ctrl_q[`E3RX_C_MAN_AIS] && ctrl_q[`E3RX_C_AUTO_AIS_DIS]
    |=> !downstream_ais_o) else $error("AIS inserted while disabled");
  count_gate_a: assert property (fec_sel != e3rx_pkg::E3RX_FEC_OOF && !gate_ok
    && !cnt_clr |=> $stable(cnt_q)) else $error("Count moved while gated");
  bit_limit_a: assert property (!cnt_clr && cnt_q < 16'hFF00 |=>
    cnt_q - $past(cnt_q) <= CNT_W'(`E3RX_FAS_BIT_MAX)) else $error("Per-frame cap exceeded");
  rai_lof_a: assert property (ctrl_q[`E3RX_C_RAI_LOF_EN] && lof_w |=> auto_rai_o)
    else $error("LOF did not raise RAI");
  rai_los_a: assert property (!ctrl_q[`E3RX_C_RAI_LOS_DIS] && los_sync |=> auto_rai_o)
    else $error("LOS did not raise RAI");
  rai_quiet_a: assert property (ctrl_q[7:4] == 4'b0111 |=> !auto_rai_o)
    else $error("RAI raised with all causes off");
  oh_mark_a: assert property (overhead_pos_i && !ctrl_q[`E3RX_C_OH_MARK_DIS]
    |=> !rx_payload_marker_n_o == 1'b0) else $error("Overhead not marked");
  lof_fast_a: assert property (oof_i && lip_sel == e3rx_pkg::E3RX_LIP_NONE
    |=> lof_w) else $error("LOF late in immediate mode");
  lof_hold_a: assert property (lip_sel == e3rx_pkg::E3RX_LIP_1MS && $rose(oof_i)
    |=> !lof_w [*8]) else $error("LOF before integration ended");
  lof_clear_a: assert property (!oof_i |=> !lof_w)
    else $error("LOF held after OOF cleared");
  resync_pulse_a: assert property ($rose(ctrl_q[`E3RX_C_RESYNC])
    |=> force_resync_o ##1 !force_resync_o) else $error("Resync pulse wrong");
  los_live_a: assert property (los_sync |=> live_a_q[`E3RX_S_LOS])
    else $error("LOS status does not follow pin");
  live_alarm_a: assert property (1'b1 |=> live_a_q[4:1] ==
    {$past(lof_w), $past(rdi_i), $past(ais_i), $past(oof_i)}) else $error("Live alarms stale");
  change_latch_a: assert property (|chg_a |=> (lat_a_q & $past(chg_a)) == $past(chg_a))
    else $error("Change not latched");
  irq_gate_a: assert property (!port_status_irq_enable_i |=> !irq_o)
    else $error("Interrupt without port enable");
  nonzero_a: assert property (1'b1 |=> live_b_q[`E3RX_S_NZ] == ($past(cnt_q) != '0))
    else $error("Nonzero bit wrong");
  nonzero_latch_a: assert property ($rose(live_b_q[`E3RX_S_NZ]) |-> lat_b_q[`E3RX_S_NZ])
    else $error("Nonzero rise not latched");

  lof_declared_c: cover property ($rose(lof_w));
  count_seen_c: cover property ($rose(live_b_q[`E3RX_S_NZ]));
  irq_seen_c: cover property ($rose(irq_o));
  resync_seen_c: cover property (force_resync_o);
endmodule

// *** src/e3rx_lof_timer.sv ***
// Out-of-frame integration timer that declares loss of frame
`timescale 1ns/1ps
`include "e3rx_cfg.svh"
module e3rx_lof_timer #(
  parameter int MS_CYCLES = `E3RX_MS_NS / `E3RX_CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic oof_i,
  input wire e3rx_pkg::e3rx_lip_t period_i,
  output logic lof_o
);
  typedef enum {
    LOF_CLEAR,
    LOF_INTEG,
    LOF_DECLARED
  } e3rx_lof_state_t;

  localparam int DW = $clog2(MS_CYCLES + 1);

  e3rx_lof_state_t state_q;
  logic [DW-1:0] div_q;
  logic [1:0] ms_q;
  logic [1:0] target;
  logic tick;

  // One-cycle enable every millisecond while integrating
  assign tick = (div_q == DW'(MS_CYCLES - 1));

  always_comb begin
    case (period_i)
      e3rx_pkg::E3RX_LIP_3MS: target = `E3RX_LIP_3MS_N;
      e3rx_pkg::E3RX_LIP_2MS: target = `E3RX_LIP_2MS_N;
      default: target = `E3RX_LIP_1MS_N;
    endcase
  end

  // Millisecond divider restarts with each new OOF so the period is whole
  always_ff @(posedge clock_i) begin
    if (reset_i || state_q != LOF_INTEG || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // Integration state; any OOF clear restarts it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= LOF_CLEAR;
      ms_q <= 2'h0;
    end else begin
      case (state_q)
        LOF_CLEAR: begin
          ms_q <= 2'h0;
          if (oof_i && period_i == e3rx_pkg::E3RX_LIP_NONE) begin
            state_q <= LOF_DECLARED;
          end else if (oof_i) begin
            state_q <= LOF_INTEG;
          end
        end
        LOF_INTEG: begin
          if (!oof_i) begin
            state_q <= LOF_CLEAR;
          end else if (period_i == e3rx_pkg::E3RX_LIP_NONE) begin
            state_q <= LOF_DECLARED;
          end else if (tick) begin
            ms_q <= ms_q + 2'h1;
            if (ms_q + 2'h1 >= target) begin
              state_q <= LOF_DECLARED;
            end
          end
        end
        LOF_DECLARED: begin
          if (!oof_i) begin
            state_q <= LOF_CLEAR;
          end
        end
        default: state_q <= LOF_CLEAR;
      endcase
    end
  end

  assign lof_o = (state_q == LOF_DECLARED);
endmodule

// *** src/e3rx_pin_sync.sv ***
// Three-stage synchroniser for a pin level, accepting a change once stages two and three agree
`timescale 1ns/1ps
`include "e3rx_cfg.svh"
module e3rx_pin_sync (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filter out a single-cycle disagreement
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule

// *** tb/e3rx_line_model.sv ***
// Line receive path model: frame strobes, service bits, FAS errors and overhead marks
`timescale 1ns/1ps
module e3rx_line_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [3:0] errs_i,
  output logic svc_strobe_o,
  output logic svc_a_raw_o,
  output logic svc_n_raw_o,
  output logic frame_strobe_o,
  output logic [3:0] fas_bit_errs_o,
  output logic fas_word_error_o,
  output logic overhead_pos_o
);
  logic [2:0] pos_q;
  logic fr;
  logic [31:0] r;
  integer seed = 32'hfd83_8ac3;
  assign fr = !reset_i && pos_q == 3'h7;
  // Quiet outputs until the first edge
  initial begin
    {svc_strobe_o, svc_a_raw_o, svc_n_raw_o, frame_strobe_o} = 4'h0;
    {fas_bit_errs_o, fas_word_error_o, overhead_pos_o} = 6'h00;
  end
  // Eight-cycle frame; the first two positions carry overhead
  always @(posedge clock_i) begin
    r = $random(seed);
    pos_q <= reset_i ? 3'h0 : pos_q + 3'h1;
    svc_strobe_o <= fr;
    frame_strobe_o <= fr;
    fas_word_error_o <= fr && errs_i != 4'h0;
    // Error lines carry junk between strobes, so a stale count is never reused
    fas_bit_errs_o <= fr ? errs_i : r[3:0];
    svc_a_raw_o <= r[4];
    svc_n_raw_o <= r[5];
    overhead_pos_o <= pos_q < 3'h2;
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the E3 receive control and status block
`timescale 1ns/1ps
`include "e3rx_cfg.svh"
module tb;
  localparam int MS = 20;
  logic clock_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, r, ex;
  logic [3:0] pstrb_i = 4'h3, fas_bit_errs_i, errs = 4'h0;
  logic signal_loss_input_i = 1'b0, oof_i = 1'b0, ais_i = 1'b0, rdi_i = 1'b0, cofa_i = 1'b0;
  logic unframed_all_ones_i = 1'b0, rx_alarm_service_bit_i = 1'b0;
  logic rx_national_service_bit_i = 1'b0, port_status_irq_enable_i = 1'b0;
  logic pready_o, pslverr_o, svc_strobe_i, svc_a_raw_i, svc_n_raw_i, frame_strobe_i;
  logic fas_word_error_i, overhead_pos_i, feac_bit_o, feac_bit_valid_o, downstream_ais_o;
  logic auto_rai_o, rx_payload_marker_n_o, force_resync_o, lof_o, irq_o;
  logic [15:0] csh = 16'h0000, c, pv, nv;
  logic run = 1'b0, fe, me, err, sv = 1'b0;
  int bad_count = 0, checked = 0, fs = 0, rs = 0, i, n, t, e;
  integer seed = 32'hfd83_8ac3;
  always #2.5 clock_i = ~clock_i;
  e3rx_ctrl_status #(.MS_CYCLES(MS)) dut (
    .clock_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .signal_loss_input_i, .oof_i, .ais_i, .rdi_i,
    .unframed_all_ones_i, .rx_alarm_service_bit_i, .rx_national_service_bit_i, .svc_strobe_i,
    .svc_a_raw_i, .svc_n_raw_i, .frame_strobe_i, .fas_bit_errs_i, .fas_word_error_i, .cofa_i,
    .overhead_pos_i, .port_status_irq_enable_i, .feac_bit_o, .feac_bit_valid_o,
    .downstream_ais_o, .auto_rai_o, .rx_payload_marker_n_o, .force_resync_o, .lof_o, .irq_o);
  e3rx_line_model pm (.clock_i, .reset_i, .errs_i(errs), .svc_strobe_o(svc_strobe_i),
    .svc_a_raw_o(svc_a_raw_i), .svc_n_raw_o(svc_n_raw_i), .frame_strobe_o(frame_strobe_i),
    .fas_bit_errs_o(fas_bit_errs_i), .fas_word_error_o(fas_word_error_i),
    .overhead_pos_o(overhead_pos_i));
  task automatic final_report();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // A wait that runs out of its bound ends the run as a failure
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  // One APB transfer; a spare edge after release keeps back-to-back calls legal
  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {16'h0000, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) tmo(k, 20);
    rd = prdata_o;
    err = pslverr_o;
    if (w && idx == `E3RX_IDX_CTRL) csh = d;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  function automatic logic [31:0] exp_cnt(input logic [1:0] s, input logic g, input logic o,
                                          input logic [3:0] k);
    if (s == 2'b00) return 32'h0000_0002;
    if (s == 2'b11) return 32'h0000_0000;
    if (o && !g) return 32'h0000_0000;
    if (s == 2'b10) return k != 4'h0 ? 32'h0000_0003 : 32'h0000_0000;
    return k > 4'ha ? 32'h0000_001e : 3 * k;
  endfunction
  // Streamed outputs are sampled mid-cycle, clear of the launching edge
  always @(negedge clock_i) begin
    if (run && feac_bit_valid_o) chk(feac_bit_o, fe);
    if (run) chk(feac_bit_valid_o, sv);
    if (run) chk(rx_payload_marker_n_o, me);
    if (svc_strobe_i) fe = csh[13] ? svc_a_raw_i : svc_n_raw_i;
    sv = svc_strobe_i;
    me = overhead_pos_i && !csh[3];
    fs += frame_strobe_i;
    rs += force_resync_o;
  end
  // Main sequence
  initial begin
    cyc(4);
    reset_i <= 1'b0;
    cyc(2);
    run = 1'b1;
    apb(1'b1, 8'h21, 16'hffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h21, 16'h0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `E3RX_IDX_CTRL, 16'h0000);
    chk(rd, 32'h0000_0000);
    // Random control and alarm mixes; period code 11 makes frame loss track OOF
    apb(1'b1, `E3RX_IDX_IE_A, 16'h01ff);
    apb(1'b1, `E3RX_IDX_CTRL, 16'h0006);
    apb(1'b1, `E3RX_IDX_LAT_A, 16'h01ff);
    pv = 16'h0000;
    for (i = 0; i < 12; i++) begin
      r = i == 0 ? 32'hffff_ffff : $random(seed);
      c = (r[15:0] & 16'h38f8) | 16'h0006;
      apb(1'b1, `E3RX_IDX_CTRL, c | 16'hc000);
      apb(1'b0, `E3RX_IDX_CTRL, 16'h0000);
      chk(rd, c);
      {signal_loss_input_i, oof_i, ais_i, rdi_i, unframed_all_ones_i, rx_alarm_service_bit_i,
       rx_national_service_bit_i, port_status_irq_enable_i} <= r[23:16];
      // One change-of-alignment pulse per mix when drawn
      cofa_i <= r[24];
      cyc(1);
      cofa_i <= 1'b0;
      cyc(9);
      nv = {7'h00, r[19], r[18], r[17], 1'b0, r[22], r[20], r[21], r[22], r[23]};
      chk(downstream_ais_o, c[12] | (!c[11] & (r[23] | r[22] | r[21])));
      chk(auto_rai_o, (c[7] & r[22]) | (!c[6] & r[23]) | (!c[5] & r[22]) | (!c[4] & r[21]));
      chk(lof_o, r[22]);
      chk(irq_o, r[16] && (pv != nv || r[24]));
      apb(1'b0, `E3RX_IDX_LIVE_A, 16'h0000);
      chk(rd, nv);
      apb(1'b0, `E3RX_IDX_LAT_A, 16'h0000);
      chk(rd, (pv ^ nv) | {r[24], 5'h00});
      apb(1'b1, `E3RX_IDX_LAT_A, 16'h01ff);
      pv = nv;
    end
    {signal_loss_input_i, oof_i, ais_i, rdi_i, unframed_all_ones_i} <= 5'h00;
    // Framing error events over three frames, each kind and gating
    for (i = 0; i < 6; i++) begin
      r = i == 0 ? 32'h0000_00f5 : $random(seed);
      c = {5'h00, r[2], r[1:0], 8'h00};
      apb(1'b1, `E3RX_IDX_CTRL, c);
      oof_i <= r[3] && c[9:8] != 2'b00;
      cyc(2);
      apb(1'b0, `E3RX_IDX_FEC_CNT, 16'h0000);
      apb(1'b1, `E3RX_IDX_LAT_B, 16'h0101);
      errs <= r[7:4];
      cyc(1);
      n = fs;
      t = 0;
      while (fs < n + 3 && t < 40) begin
        @(posedge clock_i);
        t++;
      end
      tmo(t, 40);
      if (c[9:8] == 2'b00) repeat (2) begin
        oof_i <= 1'b1;
        cyc(2);
        oof_i <= 1'b0;
        cyc(2);
      end
      errs <= 4'h0;
      cyc(3);
      ex = exp_cnt(c[9:8], r[2], r[3], r[7:4]);
      apb(1'b0, `E3RX_IDX_LIVE_B, 16'h0000);
      chk(rd, ex != 0);
      apb(1'b0, `E3RX_IDX_LAT_B, 16'h0000);
      chk(rd[0], ex != 0);
      apb(1'b0, `E3RX_IDX_FEC_CNT, 16'h0000);
      chk(rd, ex);
    end
    oof_i <= 1'b0;
    // Frame loss integration: an early drop restarts the timer
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `E3RX_IDX_CTRL, {13'h0000, i[1:0], 1'b0});
      e = (3 - i) * MS;
      oof_i <= 1'b1;
      cyc(e - 5);
      oof_i <= 1'b0;
      cyc(2);
      chk(lof_o, 1'b0);
      oof_i <= 1'b1;
      t = 0;
      while (lof_o !== 1'b1 && t < 300) begin
        @(posedge clock_i);
        t++;
      end
      tmo(t, 300);
      chk(t >= e - 2 && t <= e + 2, 1'b1);
      oof_i <= 1'b0;
      cyc(2);
      chk(lof_o, 1'b0);
    end
    // Resync fires on a rising control bit only
    n = rs;
    apb(1'b1, `E3RX_IDX_CTRL, 16'h0001);
    cyc(3);
    chk(rs - n, 1);
    apb(1'b1, `E3RX_IDX_CTRL, 16'h0001);
    cyc(3);
    chk(rs - n, 1);
    apb(1'b1, `E3RX_IDX_CTRL, 16'h0000);
    apb(1'b1, `E3RX_IDX_CTRL, 16'h0001);
    cyc(3);
    chk(rs - n, 2);
    final_report();
  end
endmodule
